// ===== apmcm_top.sv
// Cell performance monitor: forward cell insertion, block checking, reports.
// Assumes cell streams and AXI4-Lite master share mclk; nrst is synchronous.
// Summary of operation
// - Blocks count only user cells, never maintenance cells
// - Block size selectable: 128, 256, 512, 1024
// - Sender computes BIP-16 over block user payloads
// - Forward cell: sequence, counts, BIP-16, time stamp
// - Forward cell goes ahead of next user cell
// - Receiver checks cell count against count difference
// - BIP compared only when count and sequence good
// - Report values held until report is built
// - Far end returns results in backward report
// - Outgoing monitoring active generates forward cells
// - Incoming monitoring active generates backward reports
// - Report leaves within one second of forward cell
// - Reports leave in forward cell arrival order
// - Each direction generated and checked independently
// - Forward flow one way, reports the other
// - Passing backward reports are copied and read
// - Several connections monitored at once
// - End-to-end mode uses only end-to-end cells
// - End-to-end blocks kept at nominal size
// - Monitoring switched on and off by management
// - Function type 0000 forward, 0001 backward
// - Unused octets filled with 6A
// - Parity count all ones unless checks passed
// - Time stamp in 10 ns units, else ones
`timescale 1ns/1ps
`include "apmcm_map.svh"
module apmcm_top #(
  parameter int unsigned REPORT_LIMIT_CYC = `APMCM_REPORT_LIMIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Transmit cells in
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire apmcm_pkg::apmcm_cell_t tx_in_cell,
  // Transmit cells out
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output apmcm_pkg::apmcm_cell_t tx_out_cell,
  // Receive cells in
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire apmcm_pkg::apmcm_cell_t rx_in_cell,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  apmcm_pkg::apmcm_state_t s_r;
  apmcm_pkg::apmcm_state_t s_nxt;
  logic tx_rd_en;
  logic tx_wr_en;
  apmcm_pkg::apmcm_txctx_t tx_rd;
  apmcm_pkg::apmcm_txctx_t tx_wr;
  logic rx_rd_en;
  logic rx_wr_en;
  apmcm_pkg::apmcm_rxctx_t rx_rd;
  apmcm_pkg::apmcm_rxctx_t rx_wr;
  logic [1:0] tx_rd_addr;
  logic [1:0] rx_rd_addr;
  apmcm_pkg::apmcm_txctx_t tctx;
  apmcm_pkg::apmcm_rxctx_t rctx;
  apmcm_pkg::apmcm_pm_t pm_in;
  apmcm_pkg::apmcm_pm_t pm_out;
  apmcm_pkg::apmcm_pm_t pm_rx;
  logic [15:0] cbip;
  logic [15:0] exp_cnt;
  logic cnt_ok;
  logic seq_ok;
  logic chk_ok;
  logic [4:0] errs;
  logic [1:0] tc;
  logic [1:0] rc;
  logic [1:0] wc;
  logic [2:0] clr;
  logic out_fire;
  logic ts_tick;

  assign out_fire = s_r.out_valid && tx_out_ready;
  assign tx_in_ready = s_r.tx_st == apmcm_pkg::T_IDLE && !s_r.pend;
  assign rx_in_ready = s_r.rx_st == apmcm_pkg::R_IDLE && !s_r.pend;
  assign tx_out_valid = s_r.out_valid;
  assign tx_out_cell = s_r.out_cell;
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign tc = s_r.tx_cell.conn;
  assign rc = s_r.rx_cell.conn;
  assign ts_tick = s_r.ts_div == 4'(`APMCM_TS_DIV_CYC - 1);

  // Separate context stores per direction and connection
  apmcm_ctx_mem #(.W($bits(apmcm_pkg::apmcm_txctx_t))) u_txmem (
    .mclk(mclk),
    .nrst(nrst),
    .rd_en(tx_rd_en),
    .rd_addr(tx_rd_addr),
    .rd_data(tx_rd),
    .wr_en(tx_wr_en),
    .wr_addr(tc),
    .wr_data(tx_wr)
  );
  apmcm_ctx_mem #(.W($bits(apmcm_pkg::apmcm_rxctx_t))) u_rxmem (
    .mclk(mclk),
    .nrst(nrst),
    .rd_en(rx_rd_en),
    .rd_addr(rx_rd_addr),
    .rd_data(rx_rd),
    .wr_en(rx_wr_en),
    .wr_addr(rc),
    .wr_data(rx_wr)
  );

  always_comb begin
    s_nxt = s_r;
    tx_rd_en = 1'b0;
    tx_wr_en = 1'b0;
    tx_wr = '0;
    rx_rd_en = 1'b0;
    rx_wr_en = 1'b0;
    rx_wr = '0;
    tx_rd_addr = tx_in_cell.conn;
    rx_rd_addr = rx_in_cell.conn;
    tctx = s_r.tx_fresh[tc] ? '0 : tx_rd;
    rctx = s_r.rx_fresh[rc] ? '0 : rx_rd;
    pm_in = apmcm_pkg::apmcm_pm_t'(rx_in_cell.payload);
    pm_rx = apmcm_pkg::apmcm_pm_t'(s_r.rx_cell.payload);
    pm_out = apmcm_pkg::apmcm_pm_t'({48{`APMCM_FILL}});
    pm_out.oam_type = `APMCM_OAM_TYPE_PM;
    cbip = '0;
    wc = s_r.aw_addr[5:4];
    clr = 3'h0;
    // Time stamp base, one tick per 10 ns
    s_nxt.ts_div = ts_tick ? 4'h0 : s_r.ts_div + 4'h1;
    if (ts_tick) begin
      s_nxt.ts = s_r.ts + 32'h1;
    end
    // Register writes
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'h0;
      if (s_r.aw_addr < `APMCM_CONN_SPAN && s_r.aw_addr[3:0] == `APMCM_CTRL_OFS) begin
        if (s_r.w_strb[0]) begin
          s_nxt.ctrl[wc] = s_r.w_data[7:0];
          s_nxt.tx_fresh[wc] = s_r.w_data[`APMCM_CTRL_TXEN] &&
                               !s_r.ctrl[wc][`APMCM_CTRL_TXEN] || s_r.tx_fresh[wc];
          s_nxt.rx_fresh[wc] = s_r.w_data[`APMCM_CTRL_RXEN] &&
                               !s_r.ctrl[wc][`APMCM_CTRL_RXEN] || s_r.rx_fresh[wc];
        end
      end else if (s_r.aw_addr < `APMCM_CONN_SPAN &&
                   s_r.aw_addr[3:0] == `APMCM_STAT_OFS) begin
        clr = s_r.w_strb[0] ? s_r.w_data[2:0] : 3'h0;
        s_nxt.flags[wc] = s_r.flags[wc] & ~clr;
      end else if (s_r.aw_addr != `APMCM_SNOOP_ADDR) begin
        s_nxt.bresp = 2'h2;
      end
    end
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Register reads
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = 2'h0;
      s_nxt.rdata = 32'h0;
      if (s_axi_araddr < `APMCM_CONN_SPAN && s_axi_araddr[3:0] == `APMCM_CTRL_OFS) begin
        s_nxt.rdata = {24'h0, s_r.ctrl[s_axi_araddr[5:4]]};
      end else if (s_axi_araddr < `APMCM_CONN_SPAN &&
                   s_axi_araddr[3:0] == `APMCM_STAT_OFS) begin
        s_nxt.rdata = {16'h0, s_r.last_errored_parity_count[s_axi_araddr[5:4]], 5'h0,
                       s_r.flags[s_axi_araddr[5:4]]};
      end else if (s_axi_araddr == `APMCM_SNOOP_ADDR) begin
        s_nxt.rdata = {s_r.snoop_monitor_seq_number, s_r.snoop_errored_parity_count, s_r.snoop_trcc01};
      end else begin
        s_nxt.rresp = 2'h2;
      end
    end
    // Transmit side
    if (out_fire) begin
      s_nxt.out_valid = 1'b0;
      s_nxt.out_bwd = 1'b0;
    end
    unique case (s_r.tx_st)
      apmcm_pkg::T_IDLE: begin
        if (s_r.pend) begin
          s_nxt.out_cell = s_r.pend_cell;
          s_nxt.out_valid = 1'b1;
          s_nxt.out_bwd = 1'b1;
          s_nxt.pend = 1'b0;
          s_nxt.tx_st = apmcm_pkg::T_SEND;
        end else if (tx_in_valid) begin
          s_nxt.tx_cell = tx_in_cell;
          if (tx_in_cell.kind == apmcm_pkg::K_USER &&
              s_r.ctrl[tx_in_cell.conn][`APMCM_CTRL_TXEN]) begin
            tx_rd_en = 1'b1;
            s_nxt.tx_st = apmcm_pkg::T_CALC;
          end else begin
            s_nxt.out_cell = tx_in_cell;
            s_nxt.out_valid = 1'b1;
            s_nxt.tx_st = apmcm_pkg::T_SEND;
          end
        end
      end
      apmcm_pkg::T_CALC: begin
        cbip = apmcm_pkg::apmcm_bip16(s_r.tx_cell.payload);
        s_nxt.tx_fresh[tc] = 1'b0;
        tx_wr_en = 1'b1;
        tx_wr = tctx;
        if (tctx.blk >= apmcm_pkg::apmcm_nominal(s_r.ctrl[tc][3:0])) begin
          pm_out.func = `APMCM_FUNC_FWD;
          pm_out.monitor_seq_number = tctx.monitor_seq_number;
          pm_out.tuc01 = tctx.tuc01;
          pm_out.tx_high_prio_cell_count = tctx.tx_high_prio_cell_count;
          pm_out.block_error_code = tctx.bip;
          pm_out.tstamp = s_r.ctrl[tc][`APMCM_CTRL_TSEN] ? s_r.ts : 32'hffffffff;
          s_nxt.out_cell = '{conn: tc, kind: apmcm_pkg::K_PM,
                             e2e: s_r.ctrl[tc][`APMCM_CTRL_E2E], clp: 1'b0,
                             payload: pm_out};
          s_nxt.tx_st = apmcm_pkg::T_FPM;
          tx_wr.monitor_seq_number = tctx.monitor_seq_number + 8'h1;
          tx_wr.blk = 11'h1;
          tx_wr.bip = cbip;
        end else begin
          s_nxt.out_cell = s_r.tx_cell;
          s_nxt.tx_st = apmcm_pkg::T_SEND;
          tx_wr.blk = tctx.blk + 11'h1;
          tx_wr.bip = tctx.bip ^ cbip;
        end
        s_nxt.out_valid = 1'b1;
        tx_wr.tuc01 = tctx.tuc01 + 16'h1;
        tx_wr.tx_high_prio_cell_count = tctx.tx_high_prio_cell_count + 16'(!s_r.tx_cell.clp);
      end
      apmcm_pkg::T_FPM: begin
        if (out_fire) begin
          s_nxt.out_cell = s_r.tx_cell;
          s_nxt.out_valid = 1'b1;
          s_nxt.tx_st = apmcm_pkg::T_SEND;
        end
      end
      apmcm_pkg::T_SEND: begin
        if (out_fire) begin
          s_nxt.tx_st = apmcm_pkg::T_IDLE;
        end
      end
    endcase
    // Receive side
    exp_cnt = pm_rx.tuc01 - rctx.last_tuc01;
    cnt_ok = rctx.seen && rctx.blk == exp_cnt;
    seq_ok = rctx.seen && pm_rx.monitor_seq_number == rctx.last_monitor_seq_number + 8'h1;
    chk_ok = cnt_ok && seq_ok;
    errs = apmcm_pkg::apmcm_ones(pm_rx.block_error_code ^ rctx.bip);
    unique case (s_r.rx_st)
      apmcm_pkg::R_IDLE: begin
        if (rx_in_valid && rx_in_ready) begin
          s_nxt.rx_cell = rx_in_cell;
          if (s_r.ctrl[rx_in_cell.conn][`APMCM_CTRL_RXEN] &&
              (rx_in_cell.kind == apmcm_pkg::K_USER ||
               rx_in_cell.kind == apmcm_pkg::K_PM &&
               pm_in.oam_type == `APMCM_OAM_TYPE_PM && pm_in.func == `APMCM_FUNC_FWD &&
               rx_in_cell.e2e == s_r.ctrl[rx_in_cell.conn][`APMCM_CTRL_E2E])) begin
            rx_rd_en = 1'b1;
            s_nxt.rx_st = apmcm_pkg::R_CALC;
          end else if (rx_in_cell.kind == apmcm_pkg::K_PM &&
                       pm_in.oam_type == `APMCM_OAM_TYPE_PM &&
                       pm_in.func == `APMCM_FUNC_BWD) begin
            s_nxt.snoop_monitor_seq_number = pm_in.monitor_seq_number;
            s_nxt.snoop_errored_parity_count = pm_in.errored_parity_count;
            s_nxt.snoop_trcc01 = pm_in.trcc01;
          end
        end
      end
      apmcm_pkg::R_CALC: begin
        s_nxt.rx_st = apmcm_pkg::R_IDLE;
        s_nxt.rx_fresh[rc] = 1'b0;
        rx_wr_en = 1'b1;
        rx_wr = rctx;
        if (s_r.rx_cell.kind == apmcm_pkg::K_USER) begin
          rx_wr.blk = rctx.blk + 16'h1;
          rx_wr.bip = rctx.bip ^ apmcm_pkg::apmcm_bip16(s_r.rx_cell.payload);
          rx_wr.trcc01 = rctx.trcc01 + 16'h1;
          rx_wr.trcc0 = rctx.trcc0 + 16'(!s_r.rx_cell.clp);
        end else begin
          pm_out.func = `APMCM_FUNC_BWD;
          pm_out.monitor_seq_number = pm_rx.monitor_seq_number;
          pm_out.tuc01 = pm_rx.tuc01;
          pm_out.tx_high_prio_cell_count = pm_rx.tx_high_prio_cell_count;
          pm_out.trcc01 = rctx.trcc01;
          pm_out.trcc0 = rctx.trcc0;
          pm_out.errored_parity_count = chk_ok ? {3'h0, errs} : `APMCM_ERRORED_PARITY_COUNT_BAD;
          pm_out.tstamp = 32'hffffffff;
          s_nxt.pend = 1'b1;
          s_nxt.pend_cell = '{conn: rc, kind: apmcm_pkg::K_PM,
                              e2e: s_r.rx_cell.e2e, clp: 1'b0, payload: pm_out};
          s_nxt.last_errored_parity_count[rc] = pm_out.errored_parity_count;
          s_nxt.flags[rc][`APMCM_STAT_LOSS] = s_nxt.flags[rc][`APMCM_STAT_LOSS] ||
                                              rctx.seen && !cnt_ok;
          s_nxt.flags[rc][`APMCM_STAT_SEQERR] = s_nxt.flags[rc][`APMCM_STAT_SEQERR] ||
                                                rctx.seen && !seq_ok;
          s_nxt.flags[rc][`APMCM_STAT_BITERR] = s_nxt.flags[rc][`APMCM_STAT_BITERR] ||
                                                chk_ok && errs != 5'h0;
          rx_wr = '{seen: 1'b1, blk: 16'h0, bip: 16'h0, trcc01: rctx.trcc01,
                    trcc0: rctx.trcc0, last_tuc01: pm_rx.tuc01, last_monitor_seq_number: pm_rx.monitor_seq_number};
        end
      end
    endcase
    // Age of the outstanding report
    if (s_nxt.pend || s_nxt.out_bwd) begin
      s_nxt.pend_age = (&s_r.pend_age) ? s_r.pend_age : s_r.pend_age + 27'h1;
    end else begin
      s_nxt.pend_age = 27'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.tx_st <= apmcm_pkg::T_IDLE;
      s_r.rx_st <= apmcm_pkg::R_IDLE;
      s_r.ctrl <= {`APMCM_NCONN{`APMCM_CTRL_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  sequence s_fpm_taken;
    out_fire && s_r.tx_st == apmcm_pkg::T_FPM;
  endsequence
  sequence s_user_follows;
    s_r.out_valid && s_r.out_cell.kind == apmcm_pkg::K_USER;
  endsequence
  a_fpm_then_user: assert property (@(posedge mclk) disable iff (!nrst)
    s_fpm_taken |=> s_user_follows and (s_r.out_cell.conn == $past(s_r.out_cell.conn)))
    else $error("user cell did not follow forward cell");
  a_tx_user_only: assert property (@(posedge mclk) disable iff (!nrst)
    s_r.tx_st == apmcm_pkg::T_CALC |-> s_r.tx_cell.kind == apmcm_pkg::K_USER)
    else $error("non-user cell entered block");
  a_fpm_enabled: assert property (@(posedge mclk) disable iff (!nrst)
    s_r.tx_st == apmcm_pkg::T_FPM |-> s_r.ctrl[tc][`APMCM_CTRL_TXEN] &&
    s_r.out_cell.payload[379:376] == `APMCM_FUNC_FWD)
    else $error("forward cell without enable");
  a_blk_bound: assert property (@(posedge mclk) disable iff (!nrst)
    tx_wr_en |-> tx_wr.blk <= apmcm_pkg::apmcm_nominal(s_r.ctrl[tc][3:0]))
    else $error("block longer than nominal");
  a_errored_parity_count_ones: assert property (@(posedge mclk) disable iff (!nrst)
    s_r.rx_st == apmcm_pkg::R_CALC && s_r.rx_cell.kind == apmcm_pkg::K_PM && !chk_ok
    |=> s_r.pend && s_r.pend_cell.payload[223:216] == `APMCM_ERRORED_PARITY_COUNT_BAD)
    else $error("parity count not all ones");
  a_report_order: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(s_r.pend) |-> !rx_in_ready ##1 (s_r.pend || s_r.out_bwd))
    else $error("receive taken while report pending");
  a_report_age: assert property (@(posedge mclk) disable iff (!nrst)
    32'(s_r.pend_age) < REPORT_LIMIT_CYC)
    else $error("report older than one second");
  a_bwd_fields: assert property (@(posedge mclk) disable iff (!nrst)
    s_r.out_valid && s_r.out_bwd |-> s_r.out_cell.payload[351:336] == 16'h6a6a &&
    s_r.out_cell.payload[319:288] == 32'hffffffff)
    else $error("backward report fill wrong");
  a_axi_bhold: assert property (@(posedge mclk) disable iff (!nrst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

// ===== apmcm_map.svh
// Offsets, field positions, reset values and timing counts of the cell monitor.
// Assumes a 100 MHz mclk and an 8-bit AXI4-Lite byte address.
`ifndef APMCM_MAP_SVH
`define APMCM_MAP_SVH
`define APMCM_NCONN 4
`define APMCM_CONN_BITS 2
// Register offsets
`define APMCM_CTRL_OFS 4'h0
`define APMCM_STAT_OFS 4'h4
`define APMCM_CONN_SPAN 8'h40
`define APMCM_SNOOP_ADDR 8'h40
// Control fields
`define APMCM_CTRL_BLK_LSB 0
`define APMCM_CTRL_TXEN 4
`define APMCM_CTRL_RXEN 5
`define APMCM_CTRL_E2E 6
`define APMCM_CTRL_TSEN 7
`define APMCM_CTRL_RST 8'h01
// Status fields
`define APMCM_STAT_LOSS 0
`define APMCM_STAT_BITERR 1
`define APMCM_STAT_SEQERR 2
`define APMCM_STAT_ERRORED_PARITY_COUNT_LSB 8
// Block size codes
`define APMCM_BLK_CODE_1024 4'h1
`define APMCM_BLK_CODE_512 4'h2
`define APMCM_BLK_CODE_256 4'h4
`define APMCM_BLK_CODE_128 4'h8
`define APMCM_BLK_1024 11'h400
`define APMCM_BLK_512 11'h200
`define APMCM_BLK_256 11'h100
`define APMCM_BLK_128 11'h080
// Cell codes
`define APMCM_OAM_TYPE_PM 4'h2
`define APMCM_FUNC_FWD 4'h0
`define APMCM_FUNC_BWD 4'h1
`define APMCM_FILL 8'h6a
`define APMCM_ERRORED_PARITY_COUNT_BAD 8'hff
// Timing
`define APMCM_CLK_PERIOD_NS 10
`define APMCM_TS_UNIT_NS 10
`define APMCM_TS_DIV_CYC ((`APMCM_TS_UNIT_NS + `APMCM_CLK_PERIOD_NS - 1) / `APMCM_CLK_PERIOD_NS)
`define APMCM_REPORT_LIMIT_S 1
`define APMCM_REPORT_LIMIT_CYC (`APMCM_REPORT_LIMIT_S * 1000000000 / `APMCM_CLK_PERIOD_NS)
`endif

// ===== apmcm_pkg.sv
// Types of the cell monitor: cells, monitoring payloads, contexts, state.
// Assumes apmcm_map.svh is on the include path.
`include "apmcm_map.svh"
package apmcm_pkg;
  typedef enum logic [1:0] {K_USER = 2'h0, K_PM = 2'h1, K_OAM = 2'h2} apmcm_kind_t;
  typedef enum logic [3:0] {
    T_IDLE = 4'h1, T_CALC = 4'h2, T_FPM = 4'h4, T_SEND = 4'h8
  } apmcm_tx_st_t;
  typedef enum logic [1:0] {R_IDLE = 2'h1, R_CALC = 2'h2} apmcm_rx_st_t;
  typedef struct packed {
    logic [1:0] conn;
    apmcm_kind_t kind;
    logic e2e;
    logic clp;
    logic [383:0] payload;
  } apmcm_cell_t;
  typedef struct packed {
    logic [3:0] oam_type;
    logic [3:0] func;
    logic [7:0] monitor_seq_number;
    logic [15:0] tuc01;
    logic [15:0] block_error_code;
    logic [15:0] tx_high_prio_cell_count;
    logic [31:0] tstamp;
    logic [47:0] unused;
    logic [15:0] trcc0;
    logic [7:0] errored_parity_count;
    logic [15:0] trcc01;
    logic [199:0] spare;
  } apmcm_pm_t;
  typedef struct packed {
    logic [7:0] monitor_seq_number;
    logic [10:0] blk;
    logic [15:0] bip;
    logic [15:0] tuc01;
    logic [15:0] tx_high_prio_cell_count;
  } apmcm_txctx_t;
  typedef struct packed {
    logic seen;
    logic [15:0] blk;
    logic [15:0] bip;
    logic [15:0] trcc01;
    logic [15:0] trcc0;
    logic [15:0] last_tuc01;
    logic [7:0] last_monitor_seq_number;
  } apmcm_rxctx_t;
  typedef struct packed {
    apmcm_tx_st_t tx_st;
    apmcm_rx_st_t rx_st;
    apmcm_cell_t tx_cell;
    apmcm_cell_t rx_cell;
    apmcm_cell_t out_cell;
    logic out_valid;
    logic out_bwd;
    logic pend;
    apmcm_cell_t pend_cell;
    logic [26:0] pend_age;
    logic [3:0][7:0] ctrl;
    logic [3:0][2:0] flags;
    logic [3:0][7:0] last_errored_parity_count;
    logic [3:0] tx_fresh;
    logic [3:0] rx_fresh;
    logic [7:0] snoop_monitor_seq_number;
    logic [7:0] snoop_errored_parity_count;
    logic [15:0] snoop_trcc01;
    logic [3:0] ts_div;
    logic [31:0] ts;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } apmcm_state_t;
  function automatic logic [10:0] apmcm_nominal(input logic [3:0] code);
    unique case (code)
      `APMCM_BLK_CODE_128: return `APMCM_BLK_128;
      `APMCM_BLK_CODE_256: return `APMCM_BLK_256;
      `APMCM_BLK_CODE_512: return `APMCM_BLK_512;
      default: return `APMCM_BLK_1024;
    endcase
  endfunction
  function automatic logic [15:0] apmcm_bip16(input logic [383:0] p);
    logic [15:0] b;
    b = 16'h0;
    for (int i = 0; i < 24; i++) begin
      b = b ^ p[i*16 +: 16];
    end
    return b;
  endfunction
  function automatic logic [4:0] apmcm_ones(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h0;
    for (int i = 0; i < 16; i++) begin
      c = c + 5'(v[i]);
    end
    return c;
  endfunction
endpackage

// ===== apmcm_ctx_mem.sv
// Per-connection context store with registered read data.
// Assumes one write and one read per cycle, all on mclk.
`timescale 1ns/1ps
module apmcm_ctx_mem #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data
);
  logic [W-1:0] mem_r [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          mem_r[g] <= '0;
        end else if (wr_en && wr_addr == AW'(g)) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule

// ===== apmcm_peer.sv
// Peer switch: sends cells to the monitor, keeps all it emits.
// Assumes one mclk; slow accepts every other cycle.
`timescale 1ns/1ps
module apmcm_peer (
  // Clock
  input wire logic mclk,
  // To monitor
  output logic out_valid,
  input wire logic out_ready,
  output apmcm_pkg::apmcm_cell_t out_cell,
  // From monitor
  input wire logic in_valid,
  output logic in_ready,
  input wire apmcm_pkg::apmcm_cell_t in_cell
);
  apmcm_pkg::apmcm_cell_t got[$];
  logic slow = 1'b0;
  initial begin
    out_valid = 1'b0;
    out_cell = '0;
    in_ready = 1'b1;
  end
  always @(posedge mclk) begin
    if (in_valid && in_ready) got.push_back(in_cell);
    in_ready <= !slow || !in_ready;
  end
  task automatic send(input apmcm_pkg::apmcm_cell_t x);
    @(posedge mclk);
    out_cell <= x;
    out_valid <= 1'b1;
    do @(posedge mclk); while (!out_ready);
    out_valid <= 1'b0;
    out_cell <= ~x;
  endtask
endmodule

// ===== apmcm_top_tb_top.sv
// Bench for the cell monitor: registers, forward cells, reports.
// Assumes apmcm_peer on the line side.
`timescale 1ns/1ps
`include "apmcm_map.svh"
module apmcm_top_tb_top;
  logic mclk = 1'b0, nrst = 1'b0, tx_in_valid = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic tx_in_ready, tx_out_valid, tx_out_ready, rx_in_valid, rx_in_ready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] bip;
  apmcm_pkg::apmcm_cell_t tx_in_cell = '0, tx_out_cell, rx_in_cell, c;
  apmcm_pkg::apmcm_pm_t pm;
  int n_fail = 0;
  int checks_done = 0;
  apmcm_top #(.REPORT_LIMIT_CYC(64)) apmcm_top_inst (.mclk, .nrst, .tx_in_valid, .tx_in_ready,
    .tx_in_cell, .tx_out_valid, .tx_out_ready, .tx_out_cell, .rx_in_valid, .rx_in_ready,
    .rx_in_cell, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  apmcm_peer apmcm_peer_inst (.mclk, .out_valid(rx_in_valid), .out_ready(rx_in_ready),
    .out_cell(rx_in_cell), .in_valid(tx_out_valid), .in_ready(tx_out_ready),
    .in_cell(tx_out_cell));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic put(input apmcm_pkg::apmcm_cell_t x);
    @(posedge mclk);
    tx_in_cell <= x;
    tx_in_valid <= 1'b1;
    do @(posedge mclk); while (!tx_in_ready);
    tx_in_valid <= 1'b0;
  endtask
  task automatic wait_q(input int n, input int idx);
    for (int k = 0; k < 400 && apmcm_peer_inst.got.size() < n; k++) @(posedge mclk);
    chk(32'(apmcm_peer_inst.got.size()), 32'(n));
    c = apmcm_peer_inst.got[idx];
    pm = c.payload;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h20);
    chk(rv, 32'h1);
    rd(8'h80);
    chk(rv ^ {30'h0, rr}, 32'h2);
    wr(8'h00, 32'h18);
    rd(8'h00);
    chk(rv, 32'h18);
    apmcm_peer_inst.slow = 1'b1;
    bip = '0;
    for (int i = 1; i < 130; i++) begin
      c = '0;
      c.clp = i[0];
      c.payload[15:0] = 16'(i);
      if (i == 65) begin
        c.kind = apmcm_pkg::K_OAM;
        put(c);
        c.kind = apmcm_pkg::K_USER;
      end
      put(c);
      if (i < 129) bip ^= 16'(i);
    end
    wait_q(131, 129);
    chk(32'(c.kind), 32'(apmcm_pkg::K_PM));
    chk({pm.oam_type, pm.func, pm.errored_parity_count, 8'h0}, {`APMCM_OAM_TYPE_PM, 4'h0, 8'h6a, 8'h0});
    chk({pm.tuc01, pm.tx_high_prio_cell_count}, 32'h00800040);
    chk({pm.block_error_code, pm.unused[15:0]}, {bip, 16'h6a6a});
    chk(pm.tstamp, 32'hffffffff);
    chk(32'(apmcm_peer_inst.got[130].payload[15:0]), 32'd129);
    apmcm_peer_inst.slow = 1'b0;
    wr(8'h10, 32'h28);
    pm = {48{8'h6a}};
    pm.oam_type = `APMCM_OAM_TYPE_PM;
    pm.func = `APMCM_FUNC_FWD;
    pm.tuc01 = 16'h0007;
    c = '0;
    c.conn = 2'h1;
    c.kind = apmcm_pkg::K_PM;
    c.payload = pm;
    apmcm_peer_inst.send(c);
    wait_q(132, 131);
    chk({30'h0, c.conn}, 32'h1);
    chk({pm.func, pm.tuc01, pm.errored_parity_count, 4'h0}, {4'h1, 16'h0007, 8'hff, 4'h0});
    chk({pm.block_error_code, pm.unused[15:0]}, 32'h6a6a6a6a);
    chk(pm.tstamp, 32'hffffffff);
    rd(8'h14);
    chk(rv, 32'h0000ff00);
    pm = {48{8'h6a}};
    pm.oam_type = `APMCM_OAM_TYPE_PM;
    pm.func = `APMCM_FUNC_BWD;
    pm.monitor_seq_number = 8'h5a;
    pm.errored_parity_count = 8'h03;
    pm.trcc01 = 16'h1234;
    c.conn = 2'h2;
    c.payload = pm;
    apmcm_peer_inst.send(c);
    rd(8'h40);
    chk(rv, 32'h5a031234);
    print_verdict;
  end
  initial begin
    #400000;
    n_fail++;
    print_verdict;
  end
endmodule
